// >>> dv/test_ubd_decoder.sv
// self-checking bench for the boot request decoder
module test_ubd_decoder import ubd_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] INFO = 64'h5a3c_0f96_e1d2_b487; // arbitrary value
	logic clk = 0, srst = 1, setup_valid = 0, info_ready = 0, mem_wready = 0, go = 0, d;
	ubd_setup_t setup = '0;
	logic [7:0] n = 8'h00, info_data, bulk_out_data, mem_wdata;
	logic [31:0] mem_addr, branch_addr, w;
	logic setup_ack, setup_stall, info_valid, bulk_out_valid, bulk_out_ready, mem_wvalid;
	logic flush_icache, flush_dcache, cache_move, branch_valid, xfer_active, xfer_done;
	ubd_region_t xfer_region;
	int mismatches = 0, compares = 0, k;
	ubd_decoder #(.CPU_INFO(INFO)) u_ubd_decoder (
		.clk(clk),
		.srst(srst),
		.setup(setup),
		.setup_valid(setup_valid),
		.setup_ack(setup_ack),
		.setup_stall(setup_stall),
		.info_data(info_data),
		.info_valid(info_valid),
		.info_ready(info_ready),
		.bulk_out_data(bulk_out_data),
		.bulk_out_valid(bulk_out_valid),
		.bulk_out_ready(bulk_out_ready),
		.mem_wdata(mem_wdata),
		.mem_addr(mem_addr),
		.mem_wvalid(mem_wvalid),
		.mem_wready(mem_wready),
		.flush_icache(flush_icache),
		.flush_dcache(flush_dcache),
		.cache_move(cache_move),
		.branch_valid(branch_valid),
		.branch_addr(branch_addr),
		.xfer_region(xfer_region),
		.xfer_active(xfer_active),
		.xfer_done(xfer_done)
	);
	ubd_host_model u_ubd_host_model (
		.clk(clk),
		.go(go),
		.n(n),
		.bulk_out_ready(bulk_out_ready),
		.bulk_out_data(bulk_out_data),
		.bulk_out_valid(bulk_out_valid)
	);
	always #5 clk = ~clk;
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic req(input logic [7:0] t, input logic [7:0] c, input logic [31:0] v);
		tick();
		setup = '{t, c, v[31:16], v[15:0], 16'h0000};
		setup_valid = 1'b1;
		tick();
		setup_valid = 1'b0;
	endtask : req
	task automatic xfer(input logic [31:0] a, input logic [7:0] len, input ubd_region_t rg, input int st);
		req(8'h40, REQ_SET_ADDR, a);
		req(8'hc1, REQ_SET_ADDR, ~a);
		req(8'h40, REQ_SET_LEN, {24'h00_0000, len});
		chk({setup_ack, xfer_active}, 2'b11);
		n = len;
		go = 1'b1;
		k = 0;
		d = 1'b0;
		for (int i = 0; i < 2000 && !d; i++) begin
			mem_wready = i > st && $urandom_range(3) != 0;
			// memory side has taken nothing yet, so a long stall leaves the fifo full here
			if (i == st) chk({bulk_out_ready && st > 0, xfer_region}, {1'b0, rg});
			if (mem_wvalid === 1'b1 && mem_wready) begin
				chk({mem_addr, mem_wdata}, {a + k, 8'(k * 29 + 3)});
				k++;
			end
			d = xfer_done === 1'b1;
			tick();
		end
		go = 1'b0;
		chk({d, xfer_active, k}, {2'b10, 32'(len)});
		if (!d) give_verdict();
	endtask : xfer
	initial begin
		void'($urandom(64));
		repeat (10) @(posedge clk);
		#1 srst = 1'b0;
		req(8'hc0, REQ_FLUSH, 32'h0000_0000);
		chk({setup_stall, flush_icache}, 2'b10);
		req(8'h40, 8'h06, 32'h0000_0000);
		chk({setup_stall, setup_ack}, 2'b10);
		req(8'h40, REQ_FLUSH, 32'h0000_0000);
		chk({flush_icache, flush_dcache, setup_ack}, 3'b111);
		w = $urandom();
		req(8'h40, REQ_START_MOVE, w);
		chk({cache_move, branch_valid, branch_addr}, {2'b11, w});
		w = $urandom();
		req(8'h40, REQ_START_DIRECT, w);
		chk({cache_move, branch_valid, branch_addr}, {2'b01, w});
		req(8'h40, REQ_QUERY_INFO, 32'h0000_0000);
		k = 0;
		for (int i = 0; i < 300 && k < 8; i++) begin
			info_ready = 1'($urandom_range(1));
			if (info_valid === 1'b1 && info_ready) begin
				chk(info_data, INFO[8*k +: 8]);
				k++;
			end
			tick();
		end
		chk(k, 8);
		if (k != 8) give_verdict();
		xfer(32'h1000_0000, 8'h28, UBD_REGION_APB_IO, 80);
		xfer(32'h1300_0100, 8'h05, UBD_REGION_AHB_IO, 0);
		repeat (3) xfer({8'h00, 24'($urandom())}, 8'($urandom_range(33, 1)), UBD_REGION_MEM, 0);
		// a downloaded program is started through the cache move
		w = $urandom();
		req(8'h40, REQ_START_MOVE, w);
		chk({cache_move, branch_valid, branch_addr}, {2'b11, w});
		give_verdict();
	end
endmodule : test_ubd_decoder

// >>> dv/ubd_decoder_asserts.sv
// port assertions for the boot request decoder
module ubd_decoder_asserts
	import ubd_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire ubd_setup_t setup,
	input wire logic setup_valid,
	input wire logic setup_ack,
	input wire logic setup_stall,
	input wire logic info_valid,
	input wire logic [7:0] mem_wdata,
	input wire logic [31:0] mem_addr,
	input wire logic mem_wvalid,
	input wire logic mem_wready,
	input wire logic flush_icache,
	input wire logic flush_dcache,
	input wire logic cache_move,
	input wire logic branch_valid,
	input wire logic [31:0] branch_addr,
	input wire logic xfer_active
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	logic take;
	assign take = setup_valid && !xfer_active && !info_valid;
	sequence s_req(logic [7:0] c);
		take && setup.req_type == REQ_TYPE_VENDOR_OUT && setup.req_code == c;
	endsequence
	sequence s_entry;
		branch_valid && branch_addr == {$past(setup.value), $past(setup.index)};
	endsequence
	a_bad_type: assert property (take && setup.req_type != REQ_TYPE_VENDOR_OUT |=> setup_stall && !setup_ack)
		else $error("bad request type not stalled");
	a_bad_code: assert property (s_req(setup.req_code) ##0 setup.req_code > 8'h05 |=> setup_stall && !branch_valid)
		else $error("bad request code not stalled");
	a_flush_both: assert property (s_req(REQ_FLUSH) |=> setup_ack && flush_icache && flush_dcache)
		else $error("flush request missed a cache");
	a_move_start: assert property (s_req(REQ_START_MOVE) |=> cache_move ##0 s_entry)
		else $error("start with cache move wrong");
	a_direct_start: assert property (s_req(REQ_START_DIRECT) |=> !cache_move ##0 s_entry)
		else $error("direct start wrong");
	a_info_start: assert property (s_req(REQ_QUERY_INFO) |=> setup_ack ##[0:2] info_valid)
		else $error("info bytes did not start");
	a_mem_hold: assert property (mem_wvalid && !mem_wready |=> mem_wvalid && $stable(mem_addr) && $stable(mem_wdata))
		else $error("memory write changed while stalled");
	a_addr_step: assert property (mem_wvalid && mem_wready ##1 mem_wvalid |-> mem_addr == $past(mem_addr) + 32'h0000_0001)
		else $error("memory address did not step by one");
endmodule : ubd_decoder_asserts

bind ubd_decoder ubd_decoder_asserts u_ubd_decoder_asserts (.*);

// >>> dv/ubd_host_model.sv
// host bulk-out source with random pauses
module ubd_host_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] n,
	input wire logic bulk_out_ready,
	output logic [7:0] bulk_out_data,
	output logic bulk_out_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	int idx = 0;
	logic hs;
	// one process owns both outputs so each has a single driver
	initial begin
		bulk_out_valid = 1'b0;
		bulk_out_data = 8'h00;
		forever begin
			@(posedge clk);
			hs = bulk_out_valid && bulk_out_ready;
			#1;
			idx = go ? idx + int'(hs) : 0;
			// a byte offered stays put until taken
			if (!bulk_out_valid || hs) begin
				if (go && idx < n && $urandom_range(3) != 0) begin
					bulk_out_valid = 1'b1;
					bulk_out_data = 8'(idx * 29 + 3);
				end else begin
					bulk_out_valid = 1'b0;
					bulk_out_data = ~bulk_out_data;
				end
			end
		end
	end
endmodule : ubd_host_model

// >>> src/ubd_decoder.sv
// usb boot vendor request decoder with bulk data path
// Summary of operation
// - code 01h latches the 32-bit transfer address for the next bulk transfer.
// - address is value field as bits 31:16, index field as bits 15:0.
// - code 02h latches the 32-bit byte count for the next bulk transfer.
// - length is value field as bits 31:16, index field as bits 15:0.
// - code 03h flushes instruction and data caches, ignoring value and index.
// - code 04h moves data cache to instruction cache, then branches to entry.
// - entry point is value field as bits 31:16, index field as bits 15:0.
// - code 05h branches directly to the entry point without cache move.
// - all addresses are 32 bits wide over a 4 GB space.
// - decode space: APB I/O at 0x10000000, AHB I/O at 0x13000000, 16 MB each.
// - code 00h returns eight bytes of processor information in the data stage.
// - program data moves only over bulk endpoints, never in control requests.
module ubd_decoder
	import ubd_pkg::*;
#(
	parameter logic [63:0] CPU_INFO = 64'h0123_4567_89AB_CDEF, // arbitrary identification value
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic srst,
	input wire ubd_setup_t setup,
	input wire logic setup_valid,
	output logic setup_ack,
	output logic setup_stall,
	output logic [7:0] info_data,
	output logic info_valid,
	input wire logic info_ready,
	input wire logic [7:0] bulk_out_data,
	input wire logic bulk_out_valid,
	output logic bulk_out_ready,
	output logic [7:0] mem_wdata,
	output logic [31:0] mem_addr,
	output logic mem_wvalid,
	input wire logic mem_wready,
	output logic flush_icache,
	output logic flush_dcache,
	output logic cache_move,
	output logic branch_valid,
	output logic [31:0] branch_addr,
	output ubd_region_t xfer_region,
	output logic xfer_active,
	output logic xfer_done
);
	typedef enum logic [1:0] {ST_IDLE, ST_INFO, ST_XFER} ubd_state_t;

	ubd_state_t st_q, st_d;
	logic [31:0] addr_q, addr_d, len_q, len_d, cnt_q, cnt_d, word;
	logic addr_ok_q, addr_ok_d, len_ok_q, len_ok_d;
	logic [3:0] info_idx_q, info_idx_d;
	logic ack_q, ack_d, stall_q, stall_d, fl_q, fl_d, mv_q, mv_d, br_q, br_d, done_q, done_d;
	logic [31:0] br_addr_q, br_addr_d;
	logic [7:0] info_q, info_d;
	logic info_v_q, info_v_d;
	ubd_region_t reg_q, reg_d;
	logic type_ok, known, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic [31:0] wr_ptr_q, wr_ptr_d;
	logic act_q, act_d;

	// host fields concatenate: value is the upper half, index the lower
	assign word = {setup.value, setup.index};
	assign type_ok = (setup.req_type == REQ_TYPE_VENDOR_OUT);
	assign known = (setup.req_code <= REQ_START_DIRECT);

	// bulk data only enters while a counted transfer runs
	assign fifo_in_valid = bulk_out_valid && (st_q == ST_XFER) && (cnt_q != len_q);
	assign bulk_out_ready = fifo_in_ready && (st_q == ST_XFER) && (cnt_q != len_q);
	assign fifo_out_ready = mem_wready;

	ubd_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.srst(srst),
		.in_data(bulk_out_data),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready)
	);

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		len_d = len_q;
		cnt_d = cnt_q;
		addr_ok_d = addr_ok_q;
		len_ok_d = len_ok_q;
		info_idx_d = info_idx_q;
		ack_d = 1'b0;
		stall_d = 1'b0;
		fl_d = 1'b0;
		mv_d = 1'b0;
		br_d = 1'b0;
		done_d = 1'b0;
		br_addr_d = br_addr_q;
		info_d = info_q;
		info_v_d = info_v_q;
		reg_d = reg_q;
		wr_ptr_d = wr_ptr_q;
		if (fifo_out_valid && mem_wready) begin
			wr_ptr_d = wr_ptr_q + 32'h0000_0001;
		end
		unique case (st_q)
			ST_IDLE: begin
				if (setup_valid) begin
					if (!type_ok || !known) begin
						stall_d = 1'b1;
					end else begin
						ack_d = 1'b1;
						unique case (setup.req_code)
							REQ_QUERY_INFO: begin
								st_d = ST_INFO;
								info_idx_d = 4'h0;
								info_d = CPU_INFO[7:0];
								info_v_d = 1'b1;
							end
							REQ_SET_ADDR: begin
								addr_d = word;
								addr_ok_d = 1'b1;
								if (word[31:24] == APB_IO_TOP) begin
									reg_d = UBD_REGION_APB_IO;
								end else if (word[31:24] == AHB_IO_TOP) begin
									reg_d = UBD_REGION_AHB_IO;
								end else begin
									reg_d = UBD_REGION_MEM;
								end
							end
							REQ_SET_LEN: begin
								len_d = word;
								len_ok_d = 1'b1;
							end
							REQ_FLUSH: fl_d = 1'b1;
							REQ_START_MOVE: begin
								mv_d = 1'b1;
								br_d = 1'b1;
								br_addr_d = word;
							end
							default: begin
								br_d = 1'b1;
								br_addr_d = word;
							end
						endcase
						// both latched: the next bulk transfer may run
						if ((setup.req_code == REQ_SET_ADDR && len_ok_q) ||
							(setup.req_code == REQ_SET_LEN && addr_ok_q)) begin
							st_d = ST_XFER;
							cnt_d = 32'h0000_0000;
							wr_ptr_d = (setup.req_code == REQ_SET_ADDR) ? word : addr_q;
						end
					end
				end
			end
			ST_INFO: begin
				if (info_ready) begin
					if (info_idx_q == INFO_BYTES - 4'h1) begin
						info_v_d = 1'b0;
						st_d = ST_IDLE;
					end else begin
						info_idx_d = info_idx_q + 4'h1;
						info_d = CPU_INFO[8*(info_idx_q+4'h1) +: 8];
					end
				end
			end
			ST_XFER: begin
				if (fifo_in_valid && fifo_in_ready) begin
					cnt_d = cnt_q + 32'h0000_0001;
				end
				// the fifo must drain before the transfer is declared over
				if (cnt_q == len_q && !fifo_out_valid) begin
					st_d = ST_IDLE;
					done_d = 1'b1;
					addr_ok_d = 1'b0;
					len_ok_d = 1'b0;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		// registered copy of the transfer state so the output comes from a flop
		act_d = (st_d == ST_XFER);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= ST_IDLE;
			addr_q <= '0;
			len_q <= '0;
			cnt_q <= '0;
			addr_ok_q <= 1'b0;
			len_ok_q <= 1'b0;
			info_idx_q <= '0;
			ack_q <= 1'b0;
			stall_q <= 1'b0;
			fl_q <= 1'b0;
			mv_q <= 1'b0;
			br_q <= 1'b0;
			done_q <= 1'b0;
			br_addr_q <= '0;
			info_q <= '0;
			info_v_q <= 1'b0;
			reg_q <= UBD_REGION_MEM;
			wr_ptr_q <= '0;
			act_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			len_q <= len_d;
			cnt_q <= cnt_d;
			addr_ok_q <= addr_ok_d;
			len_ok_q <= len_ok_d;
			info_idx_q <= info_idx_d;
			ack_q <= ack_d;
			stall_q <= stall_d;
			fl_q <= fl_d;
			mv_q <= mv_d;
			br_q <= br_d;
			done_q <= done_d;
			br_addr_q <= br_addr_d;
			info_q <= info_d;
			info_v_q <= info_v_d;
			reg_q <= reg_d;
			wr_ptr_q <= wr_ptr_d;
			act_q <= act_d;
		end
	end

	assign setup_ack = ack_q;
	assign setup_stall = stall_q;
	assign info_data = info_q;
	assign info_valid = info_v_q;
	assign flush_icache = fl_q;
	assign flush_dcache = fl_q;
	assign cache_move = mv_q;
	assign branch_valid = br_q;
	assign branch_addr = br_addr_q;
	assign xfer_region = reg_q;
	assign xfer_active = act_q;
	assign xfer_done = done_q;
	// memory side is fed straight from the fifo head; the write address tracks it
	assign mem_wdata = fifo_out_data;
	assign mem_wvalid = fifo_out_valid;
	assign mem_addr = wr_ptr_q;
endmodule : ubd_decoder

// >>> src/ubd_fifo.sv
// synchronous fifo with valid/ready on both sides
module ubd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
		if (srst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : ubd_fifo

// >>> src/ubd_pkg.sv
// package for the usb boot vendor request decoder
package ubd_pkg;
	localparam logic [7:0] REQ_TYPE_VENDOR_OUT = 8'h40;
	localparam logic [7:0] REQ_QUERY_INFO = 8'h00;
	localparam logic [7:0] REQ_SET_ADDR = 8'h01;
	localparam logic [7:0] REQ_SET_LEN = 8'h02;
	localparam logic [7:0] REQ_FLUSH = 8'h03;
	localparam logic [7:0] REQ_START_MOVE = 8'h04;
	localparam logic [7:0] REQ_START_DIRECT = 8'h05;
	localparam logic [3:0] INFO_BYTES = 4'h8;
	localparam logic [7:0] APB_IO_TOP = 8'h10;
	localparam logic [7:0] AHB_IO_TOP = 8'h13;
	localparam int FIFO_DEPTH = 32;
	localparam int DATA_W = 8;

	typedef struct packed {
		logic [7:0] req_type;
		logic [7:0] req_code;
		logic [15:0] value;
		logic [15:0] index;
		logic [15:0] length;
	} ubd_setup_t;

	typedef enum logic [1:0] {
		UBD_REGION_MEM,
		UBD_REGION_APB_IO,
		UBD_REGION_AHB_IO
	} ubd_region_t;
endpackage : ubd_pkg
